//--- shared/kwu_pkg.sv
// Constants and types of the key wake unit
package kwu_pkg;

  // ****************************************
  // Clock and warm-up timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned WARMUP_TIME_NS = 1000;
  localparam int unsigned WARMUP_CYCLES  =
    (WARMUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] KEY_WAKE_ENABLE_IDX = 8'h31;
  localparam logic [7:0] SYSTEM_CONTROL_1_IDX = 8'h32;
  localparam logic [7:0] WAKE_STATUS_IDX      = 8'h33;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned KEY_EN_LSB   = 4;
  localparam int unsigned SC_STOP_BIT  = 0;
  localparam int unsigned SC_RELM_BIT  = 1;
  localparam logic [3:0]  KEY_EN_RESET = 4'h0;
  localparam logic        RELM_RESET   = 1'b1;
  // Pin filter idle levels: keys high, primary low
  localparam logic [4:0]  PIN_IDLE     = 5'h1e;

  // ****************************************
  // Bus responses and power states
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_STOP = 2'b01,
    ST_WARM = 2'b10
  } pm_state_t;

endpackage : kwu_pkg

//--- design/wake_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module wake_pin_sync #(
  parameter int unsigned    WIDTH     = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("wake_pin_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level moves only where stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= RST_VAL;
    end else begin
      level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    end
  end

  assign level = level_r;

endmodule : wake_pin_sync

`default_nettype wire

//--- design/key_wake_unit.sv
// Key wake unit: deep standby entry, release and warm-up
//
// Behaviour
// - Primary wake pin plus four key wake pins can release deep standby.
// - Enable register bits 7..4 enable key pins 5..2; one enables.
// - Enables reset to zero; low bits undefined; register is write-only.
// - Standby entered by control write; enabled key low releases it.
// - Level mode: primary high or key low; edge mode: primary rise.
// - Wake condition present at entry skips standby, starts warm-up.
// - Primary pin has no enable and always releases standby.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module key_wake_unit
  import kwu_pkg::*;
#(
  parameter int unsigned ADDR_W        = 12,
  parameter int unsigned WARMUP_CYC_P  = WARMUP_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              wake_primary_pin,
  input  wire logic [3:0]        key_wake_pin,
  output logic                   wake_request_async,
  output logic                   osc_stopped,
  output logic                   warmup_active
);

  if (ADDR_W < 10 || WARMUP_CYC_P < 1 || WARMUP_CYC_P > 65535) begin : g_chk
    $error("key_wake_unit: ADDR_W or WARMUP_CYC_P out of range");
  end

  localparam logic [15:0] WARM_LAST = 16'(WARMUP_CYC_P - 1);

  // ****************************************
  // Register bus slave
  // ****************************************
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic              do_write;
  logic [7:0]        widx;
  logic [7:0]        ridx;
  logic              wr_key_en;
  logic              wr_sysctl;
  logic              stop_req;

  assign awready  = !aw_hold_r && !bvalid_r;
  assign wready   = !w_hold_r && !bvalid_r;
  assign arready  = !rvalid_r;
  assign do_write = aw_hold_r && w_hold_r;
  assign widx     = waddr_r[9:2];
  assign ridx     = araddr[9:2];
  assign wr_key_en = do_write && widx == KEY_WAKE_ENABLE_IDX && wstrb_r[0];
  assign wr_sysctl = do_write && widx == SYSTEM_CONTROL_1_IDX && wstrb_r[0];
  assign stop_req  = wr_sysctl && wdata_r[SC_STOP_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        waddr_r   <= awaddr;
      end else if (do_write) begin
        aw_hold_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end else if (do_write) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (widx == KEY_WAKE_ENABLE_IDX ||
                   widx == SYSTEM_CONTROL_1_IDX) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;

  // ****************************************
  // Control registers
  // ****************************************
  logic [3:0] key_en_r;
  logic       relm_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_en_r <= KEY_EN_RESET;
    end else if (wr_key_en) begin
      key_en_r <= wdata_r[KEY_EN_LSB +: 4];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relm_r <= RELM_RESET;
    end else if (wr_sysctl) begin
      relm_r <= wdata_r[SC_RELM_BIT];
    end
  end

  // ****************************************
  // Wake detection
  // ****************************************
  logic [4:0] pin_lvl;
  logic       prim_prev_r;
  logic       prim_lvl;
  logic [3:0] key_low;
  logic       prim_rise;
  logic       abort_cond;
  logic       level_rel;
  logic       release_cond;

  wake_pin_sync #(
    .WIDTH   (5),
    .RST_VAL (PIN_IDLE)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     ({key_wake_pin, wake_primary_pin}),
    .level   (pin_lvl)
  );

  assign prim_lvl  = pin_lvl[0];
  assign key_low   = ~pin_lvl[4:1] & key_en_r;
  assign prim_rise = prim_lvl && !prim_prev_r;
  // Entry check looks at every enabled key whatever the mode
  assign abort_cond = prim_lvl || (|key_low);
  assign level_rel  = prim_lvl || (relm_r && (|key_low));
  assign release_cond = relm_r ? level_rel : prim_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prim_prev_r <= 1'b0;
    end else begin
      prim_prev_r <= prim_lvl;
    end
  end

  // Raw request for oscillator restart, needs no clock
  assign wake_request_async = wake_primary_pin ||
    (relm_r && (|(~key_wake_pin & key_en_r)));

  // ****************************************
  // Standby state machine and warm-up counter
  // ****************************************
  pm_state_t   state_r;
  logic [15:0] warm_cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (stop_req) begin
            state_r <= abort_cond ? ST_WARM : ST_STOP;
          end
        end
        ST_STOP: begin
          if (release_cond) begin
            state_r <= ST_WARM;
          end
        end
        ST_WARM: begin
          if (warm_cnt_r == WARM_LAST) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warm_cnt_r <= 16'h0;
    end else if (state_r == ST_WARM) begin
      warm_cnt_r <= warm_cnt_r + 16'h1;
    end else begin
      warm_cnt_r <= 16'h0;
    end
  end

  assign osc_stopped   = state_r == ST_STOP;
  assign warmup_active = state_r == ST_WARM;

  // ****************************************
  // Read path; enable register reads as zero
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
      case (ridx)
        KEY_WAKE_ENABLE_IDX: rdata_r <= 32'h0;
        SYSTEM_CONTROL_1_IDX: rdata_r[SC_RELM_BIT] <= relm_r;
        WAKE_STATUS_IDX: rdata_r[7:0] <= {key_low, pin_lvl[0],
                                          1'b0, state_r};
        default: rresp_r <= RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rresp  = rresp_r;
  assign rdata  = rdata_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_warm_full;
    (state_r == ST_WARM && warm_cnt_r == WARM_LAST) ##1 (state_r == ST_RUN);
  endsequence

  a_abort_entry: assert property (
    state_r == ST_RUN && stop_req && abort_cond |=> state_r == ST_WARM)
    else $error("entry with wake pending did not start warm-up");

  a_enter_stop: assert property (
    state_r == ST_RUN && stop_req && !abort_cond |=> state_r == ST_STOP)
    else $error("standby not entered");

  a_key_release: assert property (
    state_r == ST_STOP && relm_r && (|key_low) |=> state_r == ST_WARM)
    else $error("enabled key low did not release standby");

  a_level_primary: assert property (
    state_r == ST_STOP && relm_r && prim_lvl |=> state_r == ST_WARM)
    else $error("primary high did not release in level mode");

  a_primary_edge: assert property (
    state_r == ST_STOP && prim_lvl && !$past(prim_lvl) |=> state_r == ST_WARM)
    else $error("primary rise did not release standby");

  a_edge_masks_keys: assert property (
    state_r == ST_STOP && !relm_r && !prim_rise |=> state_r == ST_STOP)
    else $error("edge mode left standby without primary rise");

  a_warmup_done: assert property (
    $rose(state_r == ST_WARM) |-> ##(WARMUP_CYC_P - 1) s_warm_full)
    else $error("warm-up length wrong");

  a_enable_store: assert property (
    wr_key_en |=> key_en_r == $past(wdata_r[7:4]))
    else $error("key enable bits not stored from bits 7..4");

  a_enable_reset: assert property (
    $rose(aresetn) |-> key_en_r == 4'h0)
    else $error("key enables not zero after reset");

endmodule : key_wake_unit

`default_nettype wire

//--- verification/key_switches.sv
// Behavioural model of the key switches and the primary wake line
`timescale 1ns/1ps
`default_nettype none

module key_switches (
  input  wire logic       aclk,
  input  wire logic       slow,
  input  wire logic       prim_on,
  input  wire logic [3:0] press,
  output logic            wake_primary_pin,
  output logic [3:0]      key_wake_pin
);
  logic [4:0] d1_r;
  logic [4:0] d2_r;
  logic [4:0] d3_r;

  // ****************************************
  // Slow switches answer three cycles late
  // ****************************************
  always_ff @(posedge aclk) begin
    d1_r <= {prim_on, press};
    d2_r <= d1_r;
    d3_r <= d2_r;
  end

  // Keys pulled high, a pressed key pulls low; primary low unless asked
  assign wake_primary_pin = slow ? d3_r[4] : prim_on;
  // Key lines are digital inputs only, never analog or driven back
  assign key_wake_pin     = slow ? ~d3_r[3:0] : ~press;
endmodule : key_switches

`default_nettype wire

//--- verification/tb.sv
// Self-checking bench of the key wake unit
`timescale 1ns/1ps
`default_nettype none

module tb;
  import kwu_pkg::*;
  localparam int W = 4;
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, awready, wready;
  logic arvalid, arready, rvalid, rready, slow, prim;
  logic wake_request_async, osc_stopped, warmup_active, wake_primary_pin;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, press, en, key_wake_pin;
  logic [2:0]  awprot, arprot;
  logic [1:0]  bresp, rresp, r;
  int          n_errors, check_count, k, idx;

  key_wake_unit #(.ADDR_W(12), .WARMUP_CYC_P(W)) DUT (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .wake_primary_pin,
    .key_wake_pin, .wake_request_async, .osc_stopped, .warmup_active);

  key_switches sw (.aclk, .slow, .prim_on(prim), .press, .wake_primary_pin,
    .key_wake_pin);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ****************************************
  // Bus, compare and wait helpers
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    check_count++;
    if (seen !== ex) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  // Expected raw release request from pin levels and settings
  function automatic logic exp_req(input logic       lvl,
                                   input logic [3:0] e,
                                   input logic [3:0] p,
                                   input logic       pr);
    return pr || (lvl && (|(e & p)));
  endfunction : exp_req

  task wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask : rd

  task wake(input logic ex);
    k = 0;
    while (!warmup_active && k < 20) begin
      @(posedge aclk);
      k++;
    end
    chk("release", warmup_active, ex);
    if (warmup_active) begin
      k = 0;
      while (warmup_active) begin
        @(posedge aclk);
        k++;
      end
      chk("warm_len", k, W);
    end
  endtask : wake

  task results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  initial begin
    #80000;
    n_errors++;
    results();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, slow, prim} = '0;
    {awaddr, araddr, wdata, wstrb, press, awprot, arprot} = '0;
    aresetn = 1'b0;
    void'($urandom(32'hbba49218));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'hc4); chk("en_rd", d, 0);
    rd(12'hc8); chk("mode_rst", d, 32'h2);
    rd(12'hcc); chk("status", d, 0);
    rd(12'h000); chk("rd_unmap", r, RESP_SLVERR);
    wr(12'h010, 32'h1, 4'hf); chk("wr_unmap", r, RESP_SLVERR);
    wr(12'hc8, 32'h3, 4'h0); chk("no_strb", osc_stopped, 0);
    wr(12'hc4, 32'hf0, 4'h1); rd(12'hc4); chk("wo", d, 0);
    $display("registers done");
    for (int t = 0; t < 8; t++) begin
      en = (t == 0) ? 4'h0 : (t == 1) ? 4'hf : 4'($urandom);
      idx = $urandom_range(3, 0);
      slow <= 1'($urandom);
      wr(12'hc4, {24'h0, en, 4'h0}, 4'h1);
      rd(12'hcc); chk("keys_high", d, 0);
      wr(12'hc8, 32'h3, 4'hf);
      chk("stopped", osc_stopped, 1);
      press[idx] <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("req", wake_request_async, exp_req(1'b1, en, press, prim));
      wake(en[idx]);
      chk("osc", osc_stopped, !en[idx]);
      press <= 4'h0;
      if (!en[idx]) begin
        prim <= 1'b1;
        wake(1'b1);
        prim <= 1'b0;
      end
      repeat (10) @(posedge aclk);
    end
    $display("level release done");
    slow <= 1'b0;
    wr(12'hc4, 32'hf0, 4'h1);
    press <= 4'h1;
    repeat (8) @(posedge aclk);
    wr(12'hc8, 32'h3, 4'hf);
    chk("abort_key", {osc_stopped, warmup_active}, 2'b01);
    wake(1'b1);
    press <= 4'h0;
    wr(12'hc8, 32'h0, 4'hf);
    press <= 4'h1;
    repeat (4) @(posedge aclk);
    chk("edge_mask", wake_request_async,
        exp_req(1'b0, 4'hf, press, prim));
    press <= 4'h0;
    wr(12'hc4, 32'h0, 4'h1);
    rd(12'hc8); chk("mode_edge", d, 0);
    repeat (8) @(posedge aclk);
    wr(12'hc8, 32'h1, 4'hf);
    chk("edge_stop", osc_stopped, 1);
    rd(12'hcc); chk("st_stop", d, 32'h1);
    prim <= 1'b1;
    wake(1'b1);
    wr(12'hc8, 32'h1, 4'hf);
    chk("abort_prim", {osc_stopped, warmup_active}, 2'b01);
    wake(1'b1);
    prim <= 1'b0;
    $display("edge release done");
    results();
  end
endmodule : tb

`default_nettype wire
